//--- logic/rtu_top.sv
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module rtu_top
  import rtu_pkg::*;
  #(
    parameter int HOLD_CYCLES = UPD_HOLD_CYC,
    parameter int OSC_STOP_CYCLES = OSC_STOP_CYC
  )
  (
    // clock and resets
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic cold_reset,
    // register port
    input wire rtu_bus_req_type bus_req,
    output logic [7:0] read_data,
    // timekeeping
    input wire logic second_tick,
    input wire logic minute_tick,
    input wire logic osc_running,
    // analog monitors
    input wire rtu_monitor_type monitor,
    // interrupt pin, open drain, active low
    output logic int_n_out,
    output logic int_n_oe,
    // system interrupt and timestamp gate
    output logic irq,
    output logic timestamp_enable
  );

  // ----------------------------------------------------------
  // declarations
  // ----------------------------------------------------------
  logic [7:0] ext_ctrl; // extension_control storage
  logic update_irq_enable; // update_irq_enable
  logic clock_halt; // clock halt bit
  logic por_flag; // power-on detect flag
  logic update_event_flag; // update_event_flag
  logic low_voltage_flag; // low_voltage_flag
  logic osc_stop_flag; // osc_stop_flag
  logic [IRQ_BITS-1:0] irq_status; // sticky irq status
  logic [IRQ_BITS-1:0] irq_enable; // irq enable mask
  logic [IRQ_BITS-1:0] irq_events; // irq sources this cycle
  logic update_event; // one-cycle update event
  logic hold_expired; // interrupt low long enough
  logic osc_stopped_long; // oscillator stopped past filter
  logic osc_stopped_seen; // previous filter output
  logic osc_stop_event; // rising edge of filter output
  logic wr_flags; // write to event_flags
  logic wr_int_ctrl; // write to interrupt_control
  logic uf_clear; // software clears update flag
  logic [7:0] next_read_data; // read mux

  assign wr_flags = bus_req.write && (bus_req.addr == ADDR_FLAGS);
  assign wr_int_ctrl = bus_req.write && (bus_req.addr == ADDR_INT_CTRL);
  assign uf_clear = wr_flags && !bus_req.wdata[BIT_UF];

  // ----------------------------------------------------------
  // update event source
  // ----------------------------------------------------------
  // ticks come from the timekeeping counter as it rolls over
  always_comb
  begin
    update_event = 1'b0;
    if (!clock_halt)
      update_event = ext_ctrl[BIT_UPD_SEL] ? minute_tick : second_tick;
  end

  // ----------------------------------------------------------
  // control registers
  // ----------------------------------------------------------
  // extension register keeps all bits, only the select is used here
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      ext_ctrl <= EXT_CTRL_RESET;
    else if (bus_req.write && bus_req.addr == ADDR_EXT_CTRL)
      ext_ctrl <= bus_req.wdata;
  end

  // interrupt control: update enable and clock halt
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      update_irq_enable <= 1'b0;
      clock_halt <= 1'b0;
    end
    else if (wr_int_ctrl)
    begin
      update_irq_enable <= bus_req.wdata[BIT_UIE];
      clock_halt <= bus_req.wdata[BIT_STOP];
    end
  end

  // ----------------------------------------------------------
  // oscillator stop filter
  // ----------------------------------------------------------
  rtu_hold_timer
    #(
      .CYCLES(OSC_STOP_CYCLES)
    )
  u_osc_timer
    (
      .sys_clk(sys_clk),
      .reset(reset),
      .run(!osc_running),
      .expired(osc_stopped_long)
    );

  // edge of the filter output marks one detection
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      osc_stopped_seen <= 1'b0;
    else
      osc_stopped_seen <= osc_stopped_long;
  end

  assign osc_stop_event = osc_stopped_long && !osc_stopped_seen;

  // ----------------------------------------------------------
  // event flags, set wins over clear
  // ----------------------------------------------------------
  // power-on flag: reset sets it, a zero write clears it
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      por_flag <= 1'b1;
    else if (wr_flags && !bus_req.wdata[BIT_POR])
      por_flag <= 1'b0;
  end

  // update flag
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      update_event_flag <= 1'b0;
    else if (update_event)
      update_event_flag <= 1'b1;
    else if (uf_clear)
      update_event_flag <= 1'b0;
  end

  // low voltage flag follows power-on and oscillator stop
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      low_voltage_flag <= 1'b1;
    else if (osc_stop_event)
      low_voltage_flag <= 1'b1;
    else if (wr_flags && !bus_req.wdata[BIT_VLF])
      low_voltage_flag <= 1'b0;
  end

  // oscillator stop flag survives the power-on reset
  always_ff @(posedge sys_clk)
  begin
    if (cold_reset)
      osc_stop_flag <= 1'b0;
    else if (osc_stop_event)
      osc_stop_flag <= 1'b1;
    else if (!reset && wr_flags && !bus_req.wdata[BIT_XST])
      osc_stop_flag <= 1'b0;
  end

  // ----------------------------------------------------------
  // update interrupt pin
  // ----------------------------------------------------------
  rtu_hold_timer
    #(
      .CYCLES(HOLD_CYCLES)
    )
  u_hold_timer
    (
      .sys_clk(sys_clk),
      .reset(reset),
      .run(int_n_oe),
      .expired(hold_expired)
    );

  // pin pulls low on an enabled event, released by timer or software
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      int_n_oe <= 1'b0;
    else if (!update_irq_enable)
      int_n_oe <= 1'b0;
    else if (update_event)
      int_n_oe <= 1'b1;
    else if (uf_clear || hold_expired)
      int_n_oe <= 1'b0;
  end

  // the pin is only ever driven low
  always_ff @(posedge sys_clk)
  begin
    int_n_out <= 1'b0;
  end

  // ----------------------------------------------------------
  // timestamp gate
  // ----------------------------------------------------------
  // capture logic idles while the crystal is stopped
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      timestamp_enable <= 1'b0;
    else
      timestamp_enable <= osc_running;
  end

  // ----------------------------------------------------------
  // system interrupt controller
  // ----------------------------------------------------------
  always_comb
  begin
    irq_events = IRQ_RESET;
    irq_events[IRQ_UPDATE] = update_event;
    irq_events[IRQ_OSC_STOP] = osc_stop_event;
  end

  // sticky status, cleared by writing ones, new events win
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      irq_status <= IRQ_RESET;
    else if (bus_req.write && bus_req.addr == ADDR_IRQ_CLEAR)
      irq_status <= (irq_status & ~bus_req.wdata[IRQ_BITS-1:0]) | irq_events;
    else
      irq_status <= irq_status | irq_events;
  end

  // enable mask
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      irq_enable <= IRQ_RESET;
    else if (bus_req.write && bus_req.addr == ADDR_IRQ_ENABLE)
      irq_enable <= bus_req.wdata[IRQ_BITS-1:0];
  end

  // level output, one cycle behind status
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      irq <= 1'b0;
    else
      irq <= |(irq_status & irq_enable);
  end

  // ----------------------------------------------------------
  // read path
  // ----------------------------------------------------------
  always_comb
  begin
    next_read_data = BYTE_ZERO;
    if (bus_req.read)
    begin
      unique case (bus_req.addr)
        ADDR_EXT_CTRL:
          next_read_data = ext_ctrl;
        ADDR_FLAGS:
        begin
          next_read_data[BIT_POR] = por_flag;
          next_read_data[BIT_UF] = update_event_flag;
          next_read_data[BIT_VLF] = low_voltage_flag;
          next_read_data[BIT_XST] = osc_stop_flag;
        end
        ADDR_INT_CTRL:
        begin
          next_read_data[BIT_UIE] = update_irq_enable;
          next_read_data[BIT_STOP] = clock_halt;
        end
        ADDR_STAT_MON:
        begin
          next_read_data[BIT_EVENT_PIN_LEVEL] = monitor.event_pin;
          next_read_data[BIT_RECHARGE_COMPARE_STATUS] = monitor.recharge_cmp;
          next_read_data[BIT_BATTERY_LOW_STATUS] = monitor.battery_low;
        end
        ADDR_IRQ_STATUS:
          next_read_data[IRQ_BITS-1:0] = irq_status;
        ADDR_IRQ_ENABLE:
          next_read_data[IRQ_BITS-1:0] = irq_enable;
        default:
          next_read_data = BYTE_ZERO; // unmapped and write-only read zero
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      read_data <= BYTE_ZERO;
    else
      read_data <= next_read_data;
  end

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  property p_sec_select;
    second_tick && !ext_ctrl[BIT_UPD_SEL] && !clock_halt |=> update_event_flag;
  endproperty
  a_sec_select: assert property (p_sec_select) else $error("second event lost");
  property p_min_only;
    ext_ctrl[BIT_UPD_SEL] && !minute_tick && !update_event_flag |=> !update_event_flag;
  endproperty
  a_min_only: assert property (p_min_only) else $error("flag set without minute");
  property p_uf_hold;
    update_event_flag && !uf_clear |=> update_event_flag;
  endproperty
  a_uf_hold: assert property (p_uf_hold) else $error("update flag lost");
  property p_uf_clear;
    uf_clear && !update_event |=> !update_event_flag && !int_n_oe;
  endproperty
  a_uf_clear: assert property (p_uf_clear) else $error("update flag clear failed");
  property p_int_low; // fresh drive, not cleared by software right after
    !int_n_oe && update_event && update_irq_enable && !wr_int_ctrl ##1 !uf_clear
      |-> int_n_oe [*2];
  endproperty
  a_int_low: assert property (p_int_low) else $error("interrupt pin not driven");
  property p_int_min;
    $fell(int_n_oe) && $past(update_irq_enable) && !$past(uf_clear) |-> $past(hold_expired);
  endproperty
  a_int_min: assert property (p_int_min) else $error("interrupt released early");
  property p_int_disabled;
    !update_irq_enable |=> !int_n_oe;
  endproperty
  a_int_disabled: assert property (p_int_disabled) else $error("pin driven while disabled");
  property p_halt;
    $rose(update_event_flag) |-> !$past(clock_halt);
  endproperty
  a_halt: assert property (p_halt) else $error("event during clock halt");
  property p_vlf_xst;
    $rose(osc_stop_flag) |-> low_voltage_flag;
  endproperty
  a_vlf_xst: assert property (p_vlf_xst) else $error("low voltage flag missed stop");
  property p_xst_set;
    $rose(osc_stopped_long) |=> osc_stop_flag && low_voltage_flag;
  endproperty
  a_xst_set: assert property (p_xst_set) else $error("stop not flagged");
  property p_write_ones;
    wr_flags && bus_req.wdata == 8'hFF |=> por_flag == $past(por_flag)
      && low_voltage_flag >= $past(low_voltage_flag) && osc_stop_flag >= $past(osc_stop_flag);
  endproperty
  a_write_ones: assert property (p_write_ones) else $error("write of one changed a flag");
  property p_monitor;
    bus_req.read && bus_req.addr == ADDR_STAT_MON
      |=> read_data[BIT_EVENT_PIN_LEVEL] == $past(monitor.event_pin)
      && read_data[BIT_BATTERY_LOW_STATUS] == $past(monitor.battery_low);
  endproperty
  a_monitor: assert property (p_monitor) else $error("monitor read wrong");
  property p_timestamp;
    !osc_running [*2] |-> !timestamp_enable;
  endproperty
  a_timestamp: assert property (p_timestamp) else $error("timestamp active without osc");
  c_update_irq: cover property (update_event && update_irq_enable ##1 int_n_oe);
  c_auto_release: cover property (hold_expired ##1 !int_n_oe);
  c_osc_stop: cover property ($rose(osc_stop_flag));
  c_flag_read: cover property (bus_req.read && bus_req.addr == ADDR_FLAGS);

endmodule : rtu_top
`default_nettype wire

//--- logic/rtu_pkg.sv
// How it works
// - period select picks second or minute events
// - each update event sets sticky update flag
// - writing zero clears flag, cancels interrupt
// - enabled event drives interrupt low, self-released later
// - disabled interrupt: flag still set, pin idle
// - clock halt suppresses all update events
// - power-on reset sets detect flag, defaults registers
// - zero clears power-on flag, one ignored
// - low voltage flag set by reset or stop
// - zero clears low voltage flag, one ignored
// - oscillator stop beyond 10 ms sets flag
// - zero clears oscillator stop flag, one ignored
// - timestamp logic active only while oscillating
// - event pin level bit reads pin live
// - recharge compare bit reads comparator live
// - battery low bit reads comparator live
// - events coincide with seconds or minutes update
package rtu_pkg;

  // ----------------------------------------------------------
  // register map
  // ----------------------------------------------------------
  localparam logic [7:0] ADDR_EXT_CTRL = 8'h1D; // extension_control
  localparam logic [7:0] ADDR_FLAGS = 8'h1E; // event_flags
  localparam logic [7:0] ADDR_INT_CTRL = 8'h1F; // interrupt_control
  localparam logic [7:0] ADDR_STAT_MON = 8'h33; // status_monitor
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h40; // sticky irq status, read only
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h41; // irq enable, read/write
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h42; // irq clear, write only

  // ----------------------------------------------------------
  // field positions
  // ----------------------------------------------------------
  localparam int BIT_UPD_SEL = 5; // update_period_select
  localparam int BIT_POR = 7; // power-on detect flag
  localparam int BIT_UF = 5; // update_event_flag
  localparam int BIT_VLF = 1; // low_voltage_flag
  localparam int BIT_XST = 0; // osc_stop_flag
  localparam int BIT_UIE = 5; // update_irq_enable
  localparam int BIT_STOP = 0; // clock halt
  localparam int BIT_EVENT_PIN_LEVEL = 6; // event_pin_level
  localparam int BIT_RECHARGE_COMPARE_STATUS = 3; // recharge_compare_status
  localparam int BIT_BATTERY_LOW_STATUS = 1; // battery_low_status
  localparam int IRQ_UPDATE = 0; // irq bit: update event
  localparam int IRQ_OSC_STOP = 1; // irq bit: oscillator stop
  localparam int IRQ_BITS = 2;

  // ----------------------------------------------------------
  // reset values
  // ----------------------------------------------------------
  localparam logic [7:0] EXT_CTRL_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [IRQ_BITS-1:0] IRQ_RESET = 2'h0;

  // ----------------------------------------------------------
  // timing
  // ----------------------------------------------------------
  localparam real SYS_CLK_MHZ = 250.0; // sys_clk rate
  localparam real UPD_HOLD_MS = 7.57; // least interrupt low time
  localparam real OSC_STOP_MS = 10.0; // oscillator stop filter
  localparam int UPD_HOLD_CYC = int'($ceil(UPD_HOLD_MS * 1000.0 * SYS_CLK_MHZ));
  localparam int OSC_STOP_CYC = int'($ceil(OSC_STOP_MS * 1000.0 * SYS_CLK_MHZ));

  // ----------------------------------------------------------
  // carriers
  // ----------------------------------------------------------
  typedef struct packed {
    logic write; // write strobe
    logic read; // read strobe
    logic [7:0] addr; // register address
    logic [7:0] wdata; // write data
  } rtu_bus_req_type;

  typedef struct packed {
    logic event_pin; // event input pin level
    logic recharge_cmp; // battery above supply
    logic battery_low; // battery below low threshold
  } rtu_monitor_type;

endpackage : rtu_pkg

//--- logic/rtu_hold_timer.sv
`timescale 1ns/1ps
`default_nettype none
// counts cycles while run is high, expired rises after CYCLES of them
module rtu_hold_timer
  #(
    parameter int CYCLES = 16
  )
  (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // control
    input wire logic run,
    // result
    output logic expired
  );

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [CW-1:0] count; // cycles seen while running

  // ----------------------------------------------------------
  // counter, restarts whenever run drops
  // ----------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (reset || !run)
    begin
      count <= '0;
      expired <= 1'b0;
    end
    else if (!expired)
    begin
      if (count == LAST)
        expired <= 1'b1;
      else
        count <= count + ONE;
    end
  end

endmodule : rtu_hold_timer
`default_nettype wire

//--- verif/rtu_host.sv
`timescale 1ns/1ps
`default_nettype none
// host controller: drives the register port and watches the interrupt pin
module rtu_host
  import rtu_pkg::*;
  (
    // clock
    input wire logic sys_clk,
    // register port
    output var rtu_bus_req_type bus_req,
    input wire logic [7:0] read_data,
    // interrupt pin, open drain
    input wire logic int_n_out,
    input wire logic int_n_oe,
    output logic int_line
  );

  // pull-up holds the line high while nobody drives it
  assign int_line = int_n_oe ? int_n_out : 1'b1;

  // quiet bus at time zero
  initial bus_req = '0;

  // release the port, scramble the stale address and data
  task automatic idle();
    bus_req.write <= 1'b0;
    bus_req.read <= 1'b0;
    bus_req.addr <= ~bus_req.addr;
    bus_req.wdata <= ~bus_req.wdata;
  endtask : idle

  // one-cycle write strobe
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    bus_req <= '{write: 1'b1, read: 1'b0, addr: addr, wdata: data};
    @(posedge sys_clk);
    idle();
  endtask : wr

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge sys_clk);
    bus_req <= '{write: 1'b0, read: 1'b1, addr: addr, wdata: bus_req.wdata};
    @(posedge sys_clk);
    idle();
    #1;
    data = read_data;
  endtask : rd

  // interrupt off first, then period select, then the control byte
  task automatic cfg(input logic sel, input logic en, input logic halt);
    wr(ADDR_INT_CTRL, 8'h00);
    wr(ADDR_EXT_CTRL, {2'b00, sel, 5'b00000});
    wr(ADDR_INT_CTRL, {2'b00, en, 4'b0000, halt});
  endtask : cfg

endmodule : rtu_host
`default_nettype wire

//--- verif/test_rtu_update_irq_and_status_flags.sv
`timescale 1ns/1ps
`default_nettype none
module test_rtu_update_irq_and_status_flags
  import rtu_pkg::*;
  ;
  // ----------------------------------------------------------
  // signals
  // ----------------------------------------------------------
  localparam int HOLD = 20; // shortened interrupt hold
  localparam int OSC = 30; // shortened stop filter
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic cold_reset = 1'b1;
  logic second_tick = 1'b0;
  logic minute_tick = 1'b0;
  logic osc_running = 1'b1;
  rtu_monitor_type monitor = '0;
  rtu_bus_req_type bus_req;
  logic [7:0] read_data;
  logic int_n_out;
  logic int_n_oe;
  logic int_line;
  logic irq;
  logic timestamp_enable;
  logic [7:0] d; // read scratch
  int bad_count = 0;
  int tests_run = 0;

  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;

  // ----------------------------------------------------------
  // instances
  // ----------------------------------------------------------
  rtu_top #(.HOLD_CYCLES(HOLD), .OSC_STOP_CYCLES(OSC)) u_rtu_top (
    .sys_clk(sys_clk), .reset(reset), .cold_reset(cold_reset),
    .bus_req(bus_req), .read_data(read_data),
    .second_tick(second_tick), .minute_tick(minute_tick),
    .osc_running(osc_running), .monitor(monitor),
    .int_n_out(int_n_out), .int_n_oe(int_n_oe),
    .irq(irq), .timestamp_enable(timestamp_enable)
  );

  rtu_host u_rtu_host (
    .sys_clk(sys_clk), .bus_req(bus_req), .read_data(read_data),
    .int_n_out(int_n_out), .int_n_oe(int_n_oe), .int_line(int_line)
  );

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // read a register and compare
  task automatic chk_reg(input logic [7:0] addr, input logic [7:0] exp);
    u_rtu_host.rd(addr, d);
    chk(d, exp);
  endtask : chk_reg

  // one-cycle rollover pulses, returns just after the edge that takes them
  task automatic tick(input logic sec, input logic min);
    @(posedge sys_clk);
    second_tick <= sec;
    minute_tick <= min;
    @(posedge sys_clk);
    second_tick <= 1'b0;
    minute_tick <= 1'b0;
    #1;
  endtask : tick

  // let n edges pass, then look
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : settle

  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  // defaults after power-on, unmapped place, plain read/write
  task automatic t_reset();
    chk_reg(ADDR_FLAGS, 8'h82);
    chk_reg(ADDR_EXT_CTRL, 8'h00);
    chk_reg(ADDR_INT_CTRL, 8'h00);
    chk_reg(8'h50, 8'h00);
    u_rtu_host.wr(ADDR_EXT_CTRL, 8'hA5);
    chk_reg(ADDR_EXT_CTRL, 8'hA5);
  endtask : t_reset

  // ones are ignored, zeros clear only their own flag
  task automatic t_flag_writes();
    u_rtu_host.wr(ADDR_FLAGS, 8'hFF);
    chk_reg(ADDR_FLAGS, 8'h82);
    u_rtu_host.wr(ADDR_FLAGS, 8'h7F);
    chk_reg(ADDR_FLAGS, 8'h02);
    u_rtu_host.wr(ADDR_FLAGS, 8'hFD);
    chk_reg(ADDR_FLAGS, 8'h00);
  endtask : t_flag_writes

  // enabled second event, self release, sticky flag, system interrupt
  task automatic t_hold();
    int n;
    n = 0;
    u_rtu_host.cfg(1'b0, 1'b1, 1'b0);
    tick(1'b1, 1'b0);
    chk({7'h00, int_n_oe}, 8'h01);
    chk({7'h00, int_line}, 8'h00);
    for (int i = 0; i < 100 && int_n_oe === 1'b1; i++)
    begin
      n++;
      settle(1);
    end
    chk({7'h00, n >= HOLD && n <= HOLD + 2}, 8'h01);
    chk_reg(ADDR_FLAGS, 8'h20);
    chk({7'h00, irq}, 8'h00);
    chk_reg(ADDR_IRQ_STATUS, 8'h01);
    u_rtu_host.wr(ADDR_IRQ_ENABLE, 8'h01);
    settle(2);
    chk({7'h00, irq}, 8'h01);
    u_rtu_host.wr(ADDR_IRQ_CLEAR, 8'h01);
    settle(2);
    chk({7'h00, irq}, 8'h00);
    chk_reg(ADDR_IRQ_STATUS, 8'h00);
    u_rtu_host.wr(ADDR_FLAGS, 8'hDF);
  endtask : t_hold

  // clearing the flag cancels the low drive early
  task automatic t_clear_cancel();
    tick(1'b1, 1'b0);
    u_rtu_host.wr(ADDR_FLAGS, 8'hFF);
    settle(2);
    chk({7'h00, int_n_oe}, 8'h01);
    u_rtu_host.wr(ADDR_FLAGS, 8'hDF);
    settle(2);
    chk({7'h00, int_n_oe}, 8'h00);
    chk_reg(ADDR_FLAGS, 8'h00);
  endtask : t_clear_cancel

  // minute select ignores second rollovers
  task automatic t_minute();
    u_rtu_host.cfg(1'b1, 1'b1, 1'b0);
    tick(1'b1, 1'b0);
    chk({7'h00, int_n_oe}, 8'h00);
    chk_reg(ADDR_FLAGS, 8'h00);
    tick(1'b0, 1'b1);
    chk({7'h00, int_n_oe}, 8'h01);
    chk_reg(ADDR_FLAGS, 8'h20);
    u_rtu_host.cfg(1'b0, 1'b0, 1'b0);
    settle(2);
    chk({7'h00, int_n_oe}, 8'h00);
    u_rtu_host.wr(ADDR_FLAGS, 8'hDF);
  endtask : t_minute

  // interrupt disabled: flag set, pin never driven
  task automatic t_disabled();
    logic seen;
    seen = 1'b0;
    tick(1'b1, 1'b0);
    repeat (6)
    begin
      seen = seen | int_n_oe;
      settle(1);
    end
    chk({7'h00, seen}, 8'h00);
    chk_reg(ADDR_FLAGS, 8'h20);
    u_rtu_host.wr(ADDR_FLAGS, 8'hDF);
  endtask : t_disabled

  // clock halt: no events on either select
  task automatic t_halt();
    u_rtu_host.cfg(1'b0, 1'b1, 1'b1);
    tick(1'b1, 1'b0);
    tick(1'b0, 1'b1);
    chk({7'h00, int_n_oe}, 8'h00);
    chk_reg(ADDR_FLAGS, 8'h00);
    u_rtu_host.cfg(1'b1, 1'b1, 1'b1);
    tick(1'b0, 1'b1);
    chk_reg(ADDR_FLAGS, 8'h00);
    u_rtu_host.cfg(1'b0, 1'b0, 1'b0);
  endtask : t_halt

  // live monitor bits, every combination
  task automatic t_monitor();
    logic [2:0] m;
    for (int i = 0; i < 8; i++)
    begin
      m = i[2:0];
      @(posedge sys_clk);
      monitor <= rtu_monitor_type'(m);
      chk_reg(ADDR_STAT_MON, {1'b0, m[2], 2'b00, m[1], 1'b0, m[0], 1'b0});
    end
  endtask : t_monitor

  // oscillator stop, then a power-on reset that keeps the stop flag
  task automatic t_osc();
    u_rtu_host.wr(ADDR_EXT_CTRL, 8'h5A);
    @(posedge sys_clk);
    osc_running <= 1'b0;
    settle(2);
    chk({7'h00, timestamp_enable}, 8'h00);
    repeat (OSC + 5) @(posedge sys_clk);
    osc_running <= 1'b1;
    settle(2);
    chk({7'h00, timestamp_enable}, 8'h01);
    chk_reg(ADDR_FLAGS, 8'h03);
    chk_reg(ADDR_IRQ_STATUS, 8'h03); // update events since the last clear stay sticky
    u_rtu_host.wr(ADDR_IRQ_CLEAR, 8'h03);
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    chk_reg(ADDR_FLAGS, 8'h83);
    chk_reg(ADDR_EXT_CTRL, 8'h00);
    u_rtu_host.wr(ADDR_FLAGS, 8'hFE);
    chk_reg(ADDR_FLAGS, 8'h82);
    u_rtu_host.wr(ADDR_FLAGS, 8'hFD);
    chk_reg(ADDR_FLAGS, 8'h80);
    u_rtu_host.wr(ADDR_FLAGS, 8'h7F);
    chk_reg(ADDR_FLAGS, 8'h00);
  endtask : t_osc

  // ----------------------------------------------------------
  // verdict and main sequence
  // ----------------------------------------------------------
  task automatic print_verdict();
    if (bad_count == 0 && tests_run > 0)
    begin
      $display("== PASSED ==");
    end
    else
    begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  // reset for three cycles, then every scenario in turn
  initial
  begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    cold_reset <= 1'b0;
    t_reset();
    t_flag_writes();
    t_hold();
    t_clear_cancel();
    t_minute();
    t_disabled();
    t_halt();
    t_monitor();
    t_osc();
    print_verdict();
  end

endmodule : test_rtu_update_irq_and_status_flags
`default_nettype wire
